//--- gpf_board_model.sv
// Board side of the three pads: outside driver plus pull-up
`timescale 1ns/1ps
module gpf_board_model
  import gpf_pkg::*;
(
  input  wire logic [2:0] pad_out, // Block drive value
  input  wire logic [2:0] pad_oe,  // Block drive enable
  input  wire logic [2:0] ext_val, // Outside driver value
  input  wire logic [2:0] ext_en,  // Outside driver enable
  output logic      [2:0] pad_in   // Resolved pad level
);
  // Block wins, then the outside driver; a released pad floats to the
  // pull-up, so a stale value never lingers on an open-drain pin
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else
        pad_in[i] = 1'b1;
    end
  end
endmodule

//--- gpf_gpio_group4.sv
// Group four, pins zero to two: config registers and pin muxing
//
// Operation
// - Bit 0 one input, zero output
// - Bit 1 inverts pin value both ways
// - Bit 7 open drain, else push-pull
// - Pin zero bit 2 selects density zero
// - Pin one bits 3:2 select function
// - Pin two bit 2 selects power event
// - Power event driven active low; bit 1 inverts it as on any pin
// - Interrupt mode flags both pin edges
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module gpf_gpio_group4
  import gpf_pkg::*;
(
  input  wire logic              sys_clk,             // 100 MHz clock
  input  wire logic              reset_n,             // Standby reset
  input  wire logic [7:0]        avs_address,         // Byte address
  input  wire logic              avs_read,            // Read request
  input  wire logic              avs_write,           // Write request
  input  wire logic [GPF_DW-1:0] avs_writedata,       // Write data
  input  wire logic [3:0]        avs_byteenable,      // Byte lanes
  output logic      [GPF_DW-1:0] avs_readdata,        // Read data
  output logic                   avs_waitrequest,     // Stall
  input  wire logic [2:0]        pad_in,              // Pad levels
  output logic      [2:0]        pad_out,             // Pad values
  output logic      [2:0]        pad_oe,              // Pad enables
  input  wire logic [2:0]        gpio_out_val,        // Plain outputs
  output logic      [2:0]        gpio_in_val,         // Pin inputs
  input  wire logic              drive_density_sel_0, // Floppy density 0
  input  wire logic              drive_density_sel_1, // Floppy density 1
  input  wire logic              pme_active,          // Wake event
  output logic                   edge_irq_2           // Edge pulse
);

  // All block state
  typedef struct packed
  {
    logic [7:0] cfg0;  // Pin zero config
    logic [7:0] cfg1;  // Pin one config
    logic [7:0] cfg2;  // Pin two config
    logic       wait_; // Bus stall flag
    logic [7:0] rdata; // Read byte
    logic       prev1; // Last pin one input
    logic       irq;   // Edge pulse
  } gpf_top_s;

  gpf_top_s   s_q;      // Current state
  gpf_top_s   s_d;      // Next state
  logic       acc;      // Access accepted this edge
  logic       hit0;     // Pin zero decode
  logic       hit1;     // Pin one decode
  logic       hit2;     // Pin two decode
  gpf_sel_e   sel1;     // Pin one function
  logic [2:0] alt_en;   // Alternate owns pin
  logic [2:0] alt_val;  // Alternate value
  logic [2:0] in_raw;   // Cell inputs after polarity
  logic [7:0] cfg_a [3]; // Configs as an array for the cells

  // Address decode, shared by read and write
  always_comb
  begin
    hit0 = gpf_hit(avs_address, GPF_IDX_PIN0);
    hit1 = gpf_hit(avs_address, GPF_IDX_PIN1);
    hit2 = gpf_hit(avs_address, GPF_IDX_PIN2);
    sel1 = gpf_sel_e'(s_q.cfg1[GPF_BIT_AHI:GPF_BIT_ALT]);
  end

  // Alternate function routing
  always_comb
  begin
    // Pin zero: density select zero or plain pin
    alt_en[0]  = s_q.cfg0[GPF_BIT_ALT];
    alt_val[0] = drive_density_sel_0;
    // Pin one: only density one drives; interrupt is input
    alt_en[1]  = (sel1 == GPF_SEL_DEN1);
    alt_val[1] = drive_density_sel_1;
    // Pin two: wake event as an active-low level
    alt_en[2]  = s_q.cfg2[GPF_BIT_ALT];
    alt_val[2] = !pme_active;
  end

  assign acc = (avs_read || avs_write) && s_q.wait_;

  // Bus, register and edge logic
  always_comb
  begin
    s_d = s_q;
    // Answer one cycle after the request shows; each access
    // costs two cycles so the write lands on the sampling edge
    s_d.wait_ = !acc;
    if (acc && avs_read)
    begin
      // Reserved bits are masked in storage, so read zero
      if (hit0)
        s_d.rdata = s_q.cfg0;
      else if (hit1)
        s_d.rdata = s_q.cfg1;
      else if (hit2)
        s_d.rdata = s_q.cfg2;
      else
        s_d.rdata = 8'h00;                   // Unmapped reads zero
    end
    // Write takes effect on the edge the master sees no stall
    if (avs_write && !s_q.wait_ && avs_byteenable[0])
    begin
      if (hit0)
        s_d.cfg0 = avs_writedata[7:0] & GPF_MASK_1B;
      else if (hit1)
        s_d.cfg1 = avs_writedata[7:0] & GPF_MASK_2B;
      else if (hit2)
        s_d.cfg2 = avs_writedata[7:0] & GPF_MASK_1B;
      else
        s_d.cfg0 = s_q.cfg0;                 // Unmapped: ignored
    end
    // Both edges count; the mode gate stops stray pulses
    s_d.prev1 = in_raw[1];
    s_d.irq   = (sel1 == GPF_SEL_IRQ) &&
                (in_raw[1] != s_q.prev1);
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q       <= '0;
      s_q.cfg0  <= GPF_CFG_RST;
      s_q.cfg1  <= GPF_CFG_RST;
      s_q.cfg2  <= GPF_CFG_RST;
      s_q.wait_ <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Config bytes gathered for the cell loop
  always_comb
  begin
    cfg_a[0] = s_q.cfg0;
    cfg_a[1] = s_q.cfg1;
    cfg_a[2] = s_q.cfg2;
  end

  // One pad cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pin
      gpf_pin_cell u_cell
      (
        .sys_clk        (sys_clk),
        .reset_n        (reset_n),
        .cfg_dir_in     (cfg_a[gi][GPF_BIT_DIR]),
        .cfg_invert     (cfg_a[gi][GPF_BIT_INV]),
        .cfg_open_drain (cfg_a[gi][GPF_BIT_OD]),
        .alt_en         (alt_en[gi]),
        .alt_val        (alt_val[gi]),
        .gpio_val       (gpio_out_val[gi]),
        .pad_in         (pad_in[gi]),
        .pad_out        (pad_out[gi]),
        .pad_oe         (pad_oe[gi]),
        .in_val         (in_raw[gi])
      );
    end
  endgenerate

  // Outputs straight from flip-flops
  assign avs_readdata    = {24'h000000, s_q.rdata};
  assign avs_waitrequest = s_q.wait_;
  assign gpio_in_val     = in_raw;
  assign edge_irq_2      = s_q.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Direction bit of pin two keeps the pad quiet two edges on
  property p_dir2;
    s_q.cfg2[GPF_BIT_DIR] ##1 s_q.cfg2[GPF_BIT_DIR] |=> !pad_oe[2];
  endproperty
  a_dir2: assert property (p_dir2)
    else $error("pin two driven while input");

  // Inverted push-pull pin zero in plain mode flips its source
  property p_inv0;
    (s_q.cfg0[2:0] == 3'b010 && !s_q.cfg0[GPF_BIT_OD]) |=>
      pad_out[0] == !$past(gpio_out_val[0]);
  endproperty
  a_inv0: assert property (p_inv0)
    else $error("pin zero not inverted");

  // Open drain on pin one pulls low only
  property p_od1;
    s_q.cfg1[GPF_BIT_OD] |=> (pad_oe[1] -> !pad_out[1]);
  endproperty
  a_od1: assert property (p_od1)
    else $error("pin one open drain drove high");

  // Pin zero carries density select zero
  property p_den0;
    (s_q.cfg0[2:0] == 3'b100 && !s_q.cfg0[GPF_BIT_OD]) |=>
      pad_oe[0] && pad_out[0] == $past(drive_density_sel_0);
  endproperty
  a_den0: assert property (p_den0)
    else $error("density zero not on pin");

  // Pin one in density mode carries density select one
  property p_den1;
    (sel1 == GPF_SEL_DEN1 && s_q.cfg1[1:0] == 2'b00 &&
     !s_q.cfg1[GPF_BIT_OD]) |=>
      pad_out[1] == $past(drive_density_sel_1);
  endproperty
  a_den1: assert property (p_den1)
    else $error("density one not on pin");

  // Plain pin two follows the plain output value
  property p_plain2;
    (s_q.cfg2[2:0] == 3'b000 && !s_q.cfg2[GPF_BIT_OD]) |=>
      pad_out[2] == $past(gpio_out_val[2]);
  endproperty
  a_plain2: assert property (p_plain2)
    else $error("pin two plain value wrong");

  // Wake event pulls pin two low for either driver type, non-inverted
  property p_pme;
    (s_q.cfg2[2:0] == 3'b100 && pme_active) |=>
      pad_oe[2] && !pad_out[2];
  endproperty
  a_pme: assert property (p_pme)
    else $error("wake event not driven low");

  // Every input change in interrupt mode pulses next cycle
  // Judged from the cell output itself, so a broken history bit shows
  property p_edge;
    (sel1 == GPF_SEL_IRQ && $changed(in_raw[1])) |=> edge_irq_2;
  endproperty
  a_edge: assert property (p_edge)
    else $error("edge missed");

  // No pulse outside interrupt mode
  property p_noedge;
    (sel1 != GPF_SEL_IRQ) |=> !edge_irq_2;
  endproperty
  a_noedge: assert property (p_noedge)
    else $error("edge pulse outside interrupt mode");

  // Written byte lands with reserved bits cleared
  property p_wr1;
    (avs_write && !avs_waitrequest && hit1 && avs_byteenable[0]) |=>
      s_q.cfg1 == ($past(avs_writedata[7:0]) & GPF_MASK_2B);
  endproperty
  a_wr1: assert property (p_wr1)
    else $error("pin one write wrong");

  // Reserved bits stay zero in all three bytes
  property p_rsvd;
    s_q.cfg0[6:3] == 4'h0 && s_q.cfg1[6:4] == 3'h0 &&
    s_q.cfg2[6:3] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");

  // Stall drops exactly one cycle after a request
  property p_wait;
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest
      ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("bus answer timing wrong");

  // Open-drain density pin pulls low only for a low source
  property p_den0_od;
    (s_q.cfg0[2:0] == 3'b100 && s_q.cfg0[GPF_BIT_OD]) |=>
      pad_oe[0] == !$past(drive_density_sel_0) && !pad_out[0];
  endproperty
  a_den0_od: assert property (p_den0_od)
    else $error("density zero open drain wrong");

  // Idle wake event leaves push-pull pin two driven high
  property p_pme_idle;
    (s_q.cfg2[2:0] == 3'b100 && !s_q.cfg2[GPF_BIT_OD] && !pme_active) |=>
      pad_oe[2] && pad_out[2];
  endproperty
  a_pme_idle: assert property (p_pme_idle)
    else $error("idle wake event not high");

  // Write with lane zero off leaves every config byte alone
  property p_be_off;
    (avs_write && !avs_waitrequest && !avs_byteenable[0]) |=>
      $stable(s_q.cfg0) && $stable(s_q.cfg1) && $stable(s_q.cfg2);
  endproperty
  a_be_off: assert property (p_be_off)
    else $error("masked write changed a config");

  // Pin one read returns its byte with reserved bits zero
  property p_rd1;
    (avs_read && avs_waitrequest && hit1) |=>
      avs_readdata == {24'h000000, $past(s_q.cfg1)} &&
      avs_readdata[6:4] == 3'h0;
  endproperty
  a_rd1: assert property (p_rd1)
    else $error("pin one read data wrong");

  // Main scenarios
  c_den0: cover property (s_q.cfg0[GPF_BIT_ALT] && !s_q.cfg0[0]);
  c_irq:  cover property (edge_irq_2 ##[1:20] edge_irq_2);
  c_pme:  cover property (s_q.cfg2[GPF_BIT_ALT] && pme_active);
  c_wr:   cover property (avs_write && !avs_waitrequest && hit2);

endmodule

//--- gpf_pin_cell.sv
// One pad cell: input synchroniser, polarity and driver type
`timescale 1ns/1ps
module gpf_pin_cell
  import gpf_pkg::*;
(
  input  wire logic sys_clk,        // System clock
  input  wire logic reset_n,        // Async reset, active low
  input  wire logic cfg_dir_in,     // 1 pin is input
  input  wire logic cfg_invert,     // 1 invert pin value
  input  wire logic cfg_open_drain, // 1 open drain driver
  input  wire logic alt_en,         // Alternate function owns pin
  input  wire logic alt_val,        // Alternate function value
  input  wire logic gpio_val,       // Plain output value
  input  wire logic pad_in,         // Pad level, asynchronous
  output logic      pad_out,        // Pad drive value
  output logic      pad_oe,         // Pad drive enable, high drives
  output logic      in_val          // Pad value after polarity
);

  // All cell state
  typedef struct packed
  {
    logic sync1;  // First synchroniser stage
    logic sync2;  // Second synchroniser stage
    logic out;    // Registered pad value
    logic oe;     // Registered pad enable
    logic inval;  // Registered logic-side input
  } gpf_cell_s;

  gpf_cell_s s_q; // Current state
  gpf_cell_s s_d; // Next state
  logic      drv; // Value the pad should show

  // Next-state logic
  always_comb
  begin
    s_d       = s_q;
    s_d.sync1 = pad_in;
    s_d.sync2 = s_q.sync1;
    // Source select, then polarity on the way out
    drv       = (alt_en ? alt_val : gpio_val) ^ cfg_invert;
    if (cfg_open_drain)
    begin
      // Only ever pull low; high is left to the pull-up
      s_d.out = 1'b0;
      s_d.oe  = !cfg_dir_in && !drv;
    end
    else
    begin
      // Push-pull drives both levels
      s_d.out = drv;
      s_d.oe  = !cfg_dir_in;
    end
    // Polarity on the way in, from the second stage only
    s_d.inval = s_q.sync2 ^ cfg_invert;
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pad_out = s_q.out;
  assign pad_oe  = s_q.oe;
  assign in_val  = s_q.inval;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Input direction never drives the pad
  property p_dir_in;
    cfg_dir_in |=> !pad_oe;
  endproperty
  a_dir_in: assert property (p_dir_in)
    else $error("pad driven while input");

  // Push-pull output drives, with the source inverted as asked
  property p_pp_val;
    (!cfg_dir_in && !cfg_open_drain) |=>
      pad_oe && (pad_out ==
        $past((alt_en ? alt_val : gpio_val) ^ cfg_invert));
  endproperty
  a_pp_val: assert property (p_pp_val)
    else $error("push-pull value wrong");

  // Open drain never drives high
  property p_od;
    cfg_open_drain |=> !(pad_oe && pad_out);
  endproperty
  a_od: assert property (p_od)
    else $error("open drain drove high");

endmodule

//--- gpf_pkg.sv
// Constants and types for the group-four pin configuration block
package gpf_pkg;

  // Register indexes; byte address on the bus is index times four
  localparam logic [5:0] GPF_IDX_PIN0 = 6'h3b; // Pin zero config
  localparam logic [5:0] GPF_IDX_PIN1 = 6'h3c; // Pin one config
  localparam logic [5:0] GPF_IDX_PIN2 = 6'h3d; // Pin two config

  // Field positions inside each config byte
  localparam int GPF_BIT_DIR = 0; // 1 input, 0 output
  localparam int GPF_BIT_INV = 1; // 1 invert
  localparam int GPF_BIT_ALT = 2; // Alt select, low bit
  localparam int GPF_BIT_AHI = 3; // Alt select, high bit (pin one)
  localparam int GPF_BIT_OD  = 7; // 1 open drain, 0 push-pull

  // Reset value of every config byte
  localparam logic [7:0] GPF_CFG_RST = 8'h01;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [7:0] GPF_MASK_1B = 8'h87; // Pins zero and two
  localparam logic [7:0] GPF_MASK_2B = 8'h8f; // Pin one

  // Function select of pin one
  typedef enum logic [1:0]
  {
    GPF_SEL_GPIO = 2'b00, // Plain pin
    GPF_SEL_DEN1 = 2'b01, // Drive density select one
    GPF_SEL_IRQ  = 2'b10, // Either-edge interrupt input
    GPF_SEL_RSVD = 2'b11  // Reserved, acts as plain pin
  } gpf_sel_e;

  // Bus read data width
  localparam int GPF_DW = 32;

  // True when a byte address lands on a register index
  function automatic logic gpf_hit(input logic [7:0] addr,
                                   input logic [5:0] idx);
    gpf_hit = (addr[7:2] == idx);
  endfunction

endpackage

//--- tb_top.sv
// Self-checking bench for the group-four pin configuration block
`timescale 1ns/1ps
module tb_top
  import gpf_pkg::*;
();
  logic              sys_clk;      // Clock
  logic              reset_n;      // Reset, active low
  logic [7:0]        avs_address;  // Bus address
  logic              avs_read;     // Bus read
  logic              avs_write;    // Bus write
  logic [GPF_DW-1:0] avs_writedata; // Bus write data
  logic [3:0]        avs_byteenable; // Bus lanes
  logic [GPF_DW-1:0] avs_readdata; // Bus read data
  logic              avs_waitrequest; // Bus stall
  logic [2:0]        pad_in;       // Resolved pads
  logic [2:0]        pad_out;      // Block pad values
  logic [2:0]        pad_oe;       // Block pad enables
  logic [2:0]        gpio_out_val; // Plain outputs
  logic [2:0]        gpio_in_val;  // Pin inputs
  logic              den0;         // Density zero source
  logic              den1;         // Density one source
  logic              pme_active;   // Wake event source
  logic              edge_irq_2;   // Edge pulse
  logic [2:0]        ext_val;      // Board driver value
  logic [2:0]        ext_en;       // Board driver enable
  int                fails;        // Mismatches
  int                check_count;  // Comparisons

  gpf_gpio_group4 u_gpf_gpio_group4 (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .gpio_out_val(gpio_out_val), .gpio_in_val(gpio_in_val),
    .drive_density_sel_0(den0), .drive_density_sel_1(den1),
    .pme_active(pme_active), .edge_irq_2(edge_irq_2));

  gpf_board_model u_gpf_board_model (.pad_out(pad_out), .pad_oe(pad_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  // Free-running 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Single place that ends the run
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One bus access; entered and left at a rising edge
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h0, wd};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50)
    begin
      fails++;
      test_done();
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Register write, and read with compare
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r, {24'h0, e});
  endtask

  // Configure one pin and judge its pad two edges later
  task automatic pin(input int p, input logic [7:0] cfg, input logic oe,
                     input logic out);
    wr(GPF_IDX_PIN0 + 6'(p), cfg);
    repeat (2) @(posedge sys_clk);
    chk({pad_oe[p], pad_oe[p] & pad_out[p]}, {oe, oe & out});
  endtask

  // Register defaults, unmapped place, reserved bits, lane zero off
  task automatic t_regs();
    rd_chk(GPF_IDX_PIN0, 8'h01);
    rd_chk(GPF_IDX_PIN1, 8'h01);
    rd_chk(GPF_IDX_PIN2, 8'h01);
    wr(6'h3e, 8'hff);
    rd_chk(6'h3e, 8'h00);
    for (int i = 0; i < 3; i++)
      wr(GPF_IDX_PIN0 + 6'(i), 8'hff);
    rd_chk(GPF_IDX_PIN0, 8'h87);
    rd_chk(GPF_IDX_PIN1, 8'h8f);
    rd_chk(GPF_IDX_PIN2, 8'h87);
    avs_byteenable <= 4'h0;
    wr(GPF_IDX_PIN0, 8'h00);
    avs_byteenable <= 4'h1;
    rd_chk(GPF_IDX_PIN0, 8'h87);
  endtask

  // Direction, polarity and driver type on every pin
  task automatic t_plain();
    for (int p = 0; p < 3; p++)
    begin
      gpio_out_val[p] <= 1'b1;
      pin(p, 8'h00, 1'b1, 1'b1);
      pin(p, 8'h02, 1'b1, 1'b0);
      pin(p, 8'h80, 1'b0, 1'b0);
      gpio_out_val[p] <= 1'b0;
      pin(p, 8'h80, 1'b1, 1'b0);
      pin(p, 8'h82, 1'b0, 1'b0);
      ext_en[p]  <= 1'b1;
      ext_val[p] <= 1'b0;
      pin(p, 8'h01, 1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
      chk(gpio_in_val[p], 1'b0);
      wr(GPF_IDX_PIN0 + 6'(p), 8'h03);
      repeat (5) @(posedge sys_clk);
      chk(gpio_in_val[p], 1'b1);
      ext_en[p] <= 1'b0;
    end
  endtask

  // Alternate functions of all three pins
  task automatic t_alt();
    gpio_out_val <= 3'b000;
    den0 <= 1'b1;
    den1 <= 1'b1;
    pin(0, 8'h04, 1'b1, 1'b1);
    den0 <= 1'b0;
    pin(0, 8'h04, 1'b1, 1'b0);
    pin(0, 8'h84, 1'b1, 1'b0);
    pin(1, 8'h00, 1'b1, 1'b0);
    pin(1, 8'h04, 1'b1, 1'b1);
    pin(1, 8'h0c, 1'b1, 1'b0);
    den1 <= 1'b0;
    pin(1, 8'h04, 1'b1, 1'b0);
    pme_active <= 1'b1;
    pin(2, 8'h04, 1'b1, 1'b0);
    pin(2, 8'h84, 1'b1, 1'b0);
    pme_active <= 1'b0;
    pin(2, 8'h04, 1'b1, 1'b1);
    pin(2, 8'h84, 1'b0, 1'b0);
  endtask

  // Toggle pin one and count edge pulses
  task automatic toggle_cnt(input int exp);
    int c;
    c = 0;
    ext_val[1] <= ~ext_val[1];
    repeat (10)
    begin
      @(posedge sys_clk);
      c += int'(edge_irq_2 === 1'b1);
    end
    chk(32'(c), 32'(exp));
  endtask

  // Either edge raises one pulse, plain mode none
  task automatic t_irq();
    ext_en[1]  <= 1'b1;
    ext_val[1] <= 1'b0;
    wr(GPF_IDX_PIN1, 8'h09);
    repeat (8) @(posedge sys_clk);
    toggle_cnt(1);
    toggle_cnt(1);
    wr(GPF_IDX_PIN1, 8'h01);
    repeat (8) @(posedge sys_clk);
    toggle_cnt(0);
  endtask

  // Mid-run reset clears pads and restores every config default
  task automatic t_reset();
    wr(GPF_IDX_PIN0, 8'h02);
    wr(GPF_IDX_PIN2, 8'h84);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({avs_waitrequest, pad_oe, edge_irq_2}, 5'h10);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(GPF_IDX_PIN0, 8'h01);
    rd_chk(GPF_IDX_PIN1, 8'h01);
    rd_chk(GPF_IDX_PIN2, 8'h01);
  endtask

  // Main sequence
  initial
  begin
    fails = 0;
    check_count = 0;
    reset_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'h1;
    gpio_out_val = 3'b000;
    den0 = 1'b0;
    den1 = 1'b0;
    pme_active = 1'b0;
    ext_val = 3'b000;
    ext_en = 3'b000;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_plain();
    t_alt();
    t_irq();
    t_reset();
    test_done();
  end
endmodule
